// file: hw/rki_cfg.svh
// Timing counts and widths for the rotary knob interface.
`ifndef RKI_CFG_SVH
`define RKI_CFG_SVH
`define RKI_CLK_HZ 40000000
`define RKI_WINDOW_MS 90
`define RKI_WINDOW_CYC ((`RKI_CLK_HZ / 1000) * `RKI_WINDOW_MS)
`define RKI_DIV_STAGES 4
`endif

// file: hw/rki_pkg.sv
// Types shared by the rotary knob interface.
package rki_pkg;
    typedef enum logic [1:0] {
        RKI_IDLE,
        RKI_WINDOW,
        RKI_WAIT_CLEAR
    } rki_state_e;
    typedef logic [3:0] rki_count_t;
endpackage

// file: hw/rki_div_stage.sv
// One toggle stage of the binary divider chain.
`timescale 1ns/1ps
module rki_div_stage (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_clear,
    input wire logic i_step,
    output logic o_q,
    output logic o_carry
);
    logic q_r;
    // The stage carries on the same step that takes it from one back to zero.
    assign o_carry = i_step & q_r;
    assign o_q = q_r;
    always_ff @(posedge i_clk_sys) begin
        if (i_srst || i_clear) begin
            q_r <= 1'b0;
        end else if (i_step) begin
            q_r <= ~q_r;
        end
    end
endmodule

// file: hw/rki_knob_if.sv
// Rotary knob interface: direction latch, count window one-shot and pulse divider.
`timescale 1ns/1ps
`include "rki_cfg.svh"
// What this block does
// RL1 - Latch turning direction from knob phase A and phase B pulses.
// RL2 - Counterclockwise turning drives the direction output high.
// RL3 - Clockwise turning drives the direction output low.
// RL4 - First knob pulse edge starts a 90 ms count window one-shot.
// RL5 - Knob pulses are counted only while the count window is open.
// RL6 - Pulses during an open window never restart the one-shot.
// RL7 - Pulse counter is a divide-by-16 binary chain, each stage halving.
// RL8 - A narrow high interrupt pulse is issued once per count window.
// RL9 - Controller answers with a narrow clear pulse, low and high forms.
// RL10 - Controller reads count and direction before issuing the clear.
// RL11 - Clear zeroes the counter and idles the one-shot for a fresh window.
module rki_knob_if #(
    parameter int unsigned WINDOW_CYC = `RKI_WINDOW_CYC
) (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_knob_phase_a,
    input wire logic i_knob_phase_b,
    input wire logic i_knob_clear_low,
    input wire logic i_knob_clear_high,
    output logic o_direction,
    output logic o_window,
    output logic o_knob_interrupt_high,
    output logic [`RKI_DIV_STAGES-1:0] o_count
);
    ////////////////////////////////////////////////////////////////////////////
    rki_pkg::rki_state_e state_r;
    rki_pkg::rki_state_e state_nxt;
    logic phase_b_r;
    logic dir_r;
    logic irq_r;
    logic [31:0] timer_r;
    logic [`RKI_DIV_STAGES:0] carry;
    // Either polarity of the clear acts, so a stuck-inactive copy cannot block it.
    wire clear = ~i_knob_clear_low | i_knob_clear_high;
    // Knob pulses are low going; the falling edge of phase B is the counted event.
    wire b_fall = phase_b_r & ~i_knob_phase_b;
    wire win_open = (state_r == rki_pkg::RKI_WINDOW);
    wire win_end = win_open && (timer_r == WINDOW_CYC - 1);
    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            rki_pkg::RKI_IDLE: begin
                if (b_fall) begin
                    state_nxt = rki_pkg::RKI_WINDOW; // RL4
                end
            end
            rki_pkg::RKI_WINDOW: begin
                if (win_end) begin
                    state_nxt = rki_pkg::RKI_WAIT_CLEAR; // RL6
                end
            end
            rki_pkg::RKI_WAIT_CLEAR: begin
                state_nxt = rki_pkg::RKI_WAIT_CLEAR;
            end
            default: begin
                state_nxt = rki_pkg::RKI_IDLE;
            end
        endcase
        if (clear) begin
            state_nxt = rki_pkg::RKI_IDLE; // RL11
        end
    end
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            state_r <= rki_pkg::RKI_IDLE;
            timer_r <= 32'h0000_0000;
            phase_b_r <= 1'b1;
            dir_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            phase_b_r <= i_knob_phase_b;
            timer_r <= (win_open && !clear) ? timer_r + 32'h0000_0001 : 32'h0000_0000;
            // Phase A level at B's falling edge tells the turning sense.
            if (b_fall) begin
                dir_r <= ~i_knob_phase_a; // RL1 RL2 RL3
            end
            irq_r <= win_end && !clear; // RL8
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Only pulses inside the open window reach the divider chain.
    assign carry[0] = b_fall & win_open; // RL5
    genvar g;
    generate
        for (g = 0; g < `RKI_DIV_STAGES; g++) begin : g_stage
            rki_div_stage u_stage (
                .i_clk_sys(i_clk_sys),
                .i_srst(i_srst),
                .i_clear(clear), // RL11
                .i_step(carry[g]), // RL7
                .o_q(o_count[g]),
                .o_carry(carry[g+1])
            );
        end
    endgenerate
    assign o_direction = dir_r;
    assign o_window = win_open;
    assign o_knob_interrupt_high = irq_r;
    ////////////////////////////////////////////////////////////////////////////
    property p_window_start;
        @(posedge i_clk_sys) disable iff (i_srst)
        (state_r == rki_pkg::RKI_IDLE && b_fall && !clear) |=> win_open;
    endproperty
    a_window_start: assert property (p_window_start) else $error("window did not open"); // RL4
    property p_no_retrigger;
        @(posedge i_clk_sys) disable iff (i_srst)
        (win_open && b_fall && !clear && !win_end) |=> (timer_r == $past(timer_r) + 1);
    endproperty
    a_no_retrigger: assert property (p_no_retrigger) else $error("window restarted"); // RL6
    property p_irq_once;
        @(posedge i_clk_sys) disable iff (i_srst)
        irq_r |=> !irq_r;
    endproperty
    a_irq_once: assert property (p_irq_once) else $error("interrupt wider than one cycle"); // RL8
    property p_irq_cause;
        @(posedge i_clk_sys) disable iff (i_srst)
        $rose(irq_r) |-> $past(win_end);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("interrupt without window end"); // RL8
    property p_no_count_outside;
        @(posedge i_clk_sys) disable iff (i_srst)
        (!win_open && !clear) |=> (o_count == $past(o_count));
    endproperty
    a_no_count_outside: assert property (p_no_count_outside) else $error("count outside window"); // RL5
    property p_count_step;
        @(posedge i_clk_sys) disable iff (i_srst)
        (carry[0] && !clear) |=> (o_count == $past(o_count) + 4'h1);
    endproperty
    a_count_step: assert property (p_count_step) else $error("divider did not advance"); // RL7
    property p_clear;
        @(posedge i_clk_sys) disable iff (i_srst)
        clear |=> (o_count == 4'h0 && state_r == rki_pkg::RKI_IDLE);
    endproperty
    a_clear: assert property (p_clear) else $error("clear failed"); // RL11
    property p_dir;
        @(posedge i_clk_sys) disable iff (i_srst)
        b_fall |=> (o_direction == !$past(i_knob_phase_a));
    endproperty
    a_dir: assert property (p_dir) else $error("direction not latched"); // RL1
    property p_ccw;
        @(posedge i_clk_sys) disable iff (i_srst)
        (b_fall && !i_knob_phase_a) |=> o_direction;
    endproperty
    a_ccw: assert property (p_ccw) else $error("ccw not high"); // RL2
    property p_cw;
        @(posedge i_clk_sys) disable iff (i_srst)
        (b_fall && i_knob_phase_a) |=> !o_direction;
    endproperty
    a_cw: assert property (p_cw) else $error("cw not low"); // RL3
    property p_dir_hold;
        @(posedge i_clk_sys) disable iff (i_srst)
        !b_fall |=> $stable(o_direction);
    endproperty
    a_dir_hold: assert property (p_dir_hold) else $error("direction changed without edge"); // RL1
    property p_window_hold;
        @(posedge i_clk_sys) disable iff (i_srst)
        (win_open && !win_end && !clear) |=> win_open;
    endproperty
    a_window_hold: assert property (p_window_hold) else $error("window closed early"); // RL4
    property p_timer_start;
        @(posedge i_clk_sys) disable iff (i_srst)
        $rose(win_open) |-> (timer_r == 32'h0000_0000);
    endproperty
    a_timer_start: assert property (p_timer_start) else $error("window timer not at zero"); // RL4
    property p_idle_closed;
        @(posedge i_clk_sys) disable iff (i_srst)
        (state_r == rki_pkg::RKI_IDLE && !b_fall && !clear) |=> !win_open;
    endproperty
    a_idle_closed: assert property (p_idle_closed) else $error("window opened without edge"); // RL4
    property p_window_close;
        @(posedge i_clk_sys) disable iff (i_srst)
        (win_end && !clear) |=> (state_r == rki_pkg::RKI_WAIT_CLEAR);
    endproperty
    a_window_close: assert property (p_window_close) else $error("window did not close"); // RL6
    property p_wait_hold;
        @(posedge i_clk_sys) disable iff (i_srst)
        (state_r == rki_pkg::RKI_WAIT_CLEAR && !clear) |=> (state_r == rki_pkg::RKI_WAIT_CLEAR);
    endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("window reopened before clear"); // RL6
    property p_irq_after_end;
        @(posedge i_clk_sys) disable iff (i_srst)
        (win_end && !clear) |=> o_knob_interrupt_high;
    endproperty
    a_irq_after_end: assert property (p_irq_after_end) else $error("interrupt missing"); // RL8
    property p_irq_idle;
        @(posedge i_clk_sys) disable iff (i_srst)
        (state_r == rki_pkg::RKI_IDLE) |-> !o_knob_interrupt_high;
    endproperty
    a_irq_idle: assert property (p_irq_idle) else $error("interrupt while idle"); // RL8
    property p_stage_wrap;
        @(posedge i_clk_sys) disable iff (i_srst)
        (carry[`RKI_DIV_STAGES] && !clear) |=> (o_count == 4'h0);
    endproperty
    a_stage_wrap: assert property (p_stage_wrap) else $error("divider did not wrap"); // RL7
    property p_clear_irq;
        @(posedge i_clk_sys) disable iff (i_srst)
        clear |=> !o_knob_interrupt_high;
    endproperty
    a_clear_irq: assert property (p_clear_irq) else $error("interrupt after clear"); // RL11
    property p_count_fresh;
        @(posedge i_clk_sys) disable iff (i_srst)
        $rose(win_open) |-> (o_count == 4'h0);
    endproperty
    a_count_fresh: assert property (p_count_fresh) else $error("window opened with old count"); // RL11
    c_window: cover property (@(posedge i_clk_sys) disable iff (i_srst) $rose(win_open));
    c_irq: cover property (@(posedge i_clk_sys) disable iff (i_srst) irq_r);
    c_clear_wait: cover property (@(posedge i_clk_sys) disable iff (i_srst)
        (state_r == rki_pkg::RKI_WAIT_CLEAR) && clear);
    c_wrap: cover property (@(posedge i_clk_sys) disable iff (i_srst)
        carry[`RKI_DIV_STAGES]);
    c_high_clear: cover property (@(posedge i_clk_sys) disable iff (i_srst)
        $rose(i_knob_clear_high));
endmodule

// file: verification/rki_ctrl_model.sv
// Controller model that answers each knob interrupt with one clear pulse.
`timescale 1ns/1ps
module rki_ctrl_model #(
    parameter int DELAY = 6
) (
    input wire logic i_clk_sys,
    input wire logic i_irq,
    input wire logic i_use_high,
    output logic o_clear_low,
    output logic o_clear_high
);
    initial begin
        o_clear_low = 1'h1;
        o_clear_high = 1'h0;
        forever begin
            @(posedge i_clk_sys iff i_irq);
            // The delay leaves the count and direction readable before the clear.
            repeat (DELAY) @(negedge i_clk_sys);
            if (i_use_high) begin
                o_clear_high = 1'h1;
            end else begin
                o_clear_low = 1'h0;
            end
            @(negedge i_clk_sys);
            o_clear_low = 1'h1;
            o_clear_high = 1'h0;
        end
    end
endmodule

// file: verification/rki_knob_if_tb.sv
// Self-checking bench for the rotary knob interface.
`timescale 1ns/1ps
module rki_knob_if_tb;
    logic clk = 1'h0, srst = 1'h1, pa = 1'h1, pb = 1'h1, use_high = 1'h0;
    logic clr_l, clr_h, dir, win, irq;
    logic [3:0] cnt;
    int mismatches = 0, cmp_count = 0, cycles = 0;
    always #12.5 clk = ~clk;
    rki_knob_if #(.WINDOW_CYC(50)) rki_knob_if_i (.i_clk_sys(clk), .i_srst(srst),
        .i_knob_phase_a(pa), .i_knob_phase_b(pb), .i_knob_clear_low(clr_l),
        .i_knob_clear_high(clr_h), .o_direction(dir), .o_window(win),
        .o_knob_interrupt_high(irq), .o_count(cnt));
    rki_ctrl_model rki_ctrl_model_i (.i_clk_sys(clk), .i_irq(irq), .i_use_high(use_high),
        .o_clear_low(clr_l), .o_clear_high(clr_h));
    task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // A window with margin takes under 200 cycles; a hang is cut well past that.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            end_of_test();
        end
    end
    task automatic step(input logic a);
        @(negedge clk);
        pa = a;
        pb = 1'h0;
        @(negedge clk);
        pb = 1'h1;
    endtask
    task automatic wait_irq(input int lim);
        int n;
        n = 0;
        while (irq !== 1'h1 && n < lim) begin
            @(negedge clk);
            n++;
        end
        check("irq", 4'(irq), 4'h1);
        @(negedge clk);
        check("irq_narrow", 4'(irq), 4'h0);
    endtask
    task automatic t_open;
        step(1'h0);
        check("dir_ccw", 4'(dir), 4'h1);
        check("win_open", 4'(win), 4'h1);
        check("cnt_first", cnt, 4'h0);
    endtask
    // Seventeen counted falls wrap the chain once; a restart would miss the bound.
    task automatic t_count;
        for (int i = 0; i < 17; i++) begin
            step(1'h1);
        end
        check("dir_cw", 4'(dir), 4'h0);
        check("cnt_wrap", cnt, 4'h1);
        wait_irq(20);
    endtask
    task automatic t_after;
        step(1'h0);
        check("win_shut", 4'(win), 4'h0);
        check("cnt_held", cnt, 4'h1);
        check("dir_late", 4'(dir), 4'h1);
        repeat (5) @(negedge clk);
        check("cnt_clr", cnt, 4'h0);
        step(1'h1);
        check("win_fresh", 4'(win), 4'h1);
        check("cnt_fresh", cnt, 4'h0);
    endtask
    task automatic t_high;
        use_high = 1'h1;
        // The first fall only opens the window, so three falls leave a count of two.
        step(1'h1);
        step(1'h1);
        step(1'h1);
        check("cnt_two", cnt, 4'h2);
        wait_irq(60);
        repeat (8) @(negedge clk);
        check("cnt_hclr", cnt, 4'h0);
        check("win_hclr", 4'(win), 4'h0);
    endtask
    initial begin
        repeat (20) @(negedge clk);
        check("rst_cnt", cnt, 4'h0);
        srst = 1'h0;
        t_open();
        t_count();
        t_after();
        wait_irq(60);
        repeat (8) @(negedge clk);
        t_high();
        end_of_test();
    end
endmodule
